// ### pkg/sst_consts.svh
// offsets, field positions, reset values and frame timing of the transfer unit
`ifndef SST_CONSTS_SVH
`define SST_CONSTS_SVH

`define SST_OFS_DATA_A 8'h00
`define SST_OFS_DATA_B 8'h04
`define SST_OFS_RX_A 8'h08
`define SST_OFS_RX_B 8'h0c
`define SST_OFS_TX_A 8'h10
`define SST_OFS_TX_B 8'h14
`define SST_OFS_CTRL 8'h18
`define SST_OFS_STATUS 8'h1c

`define SST_ADDR_IFACE 7
`define SST_CTRL_EN_B 7
`define SST_CTRL_EN_A 6
`define SST_CTRL_TYPE_B_HI 5
`define SST_CTRL_TYPE_B_LO 3
`define SST_CTRL_TYPE_A_HI 2
`define SST_CTRL_TYPE_A_LO 0
`define SST_STAT_OPEN 1
`define SST_STAT_OVF 0

`define SST_REG_RESET 8'h00

`define SST_FRAME_US 125
`define SST_RCL_KHZ 4096
`define SST_FRAME_RCL ((`SST_RCL_KHZ * `SST_FRAME_US) / 1000)
`define SST_CLOSE_PER_CHAN 16
`define SST_CLOSE_EXTRA 1

`define SST_RESP_OKAY 2'b00
`define SST_RESP_SLVERR 2'b10

`endif

// ### pkg/sst_pkg.sv
// types shared by the synchronous transfer unit
package sst_pkg;

    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } sst_axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sst_axil_rsp_t;

    // one access to data memory (pcm) or control memory data field (cfi)
    typedef struct packed {
        logic req;
        logic we;
        logic cm_sel;
        logic [6:0] addr;
        logic [7:0] wdata;
        logic [7:0] wmask;
    } sst_mem_req_t;

    typedef enum logic [5:0] {
        SST_OPEN = 6'b000001,
        SST_OVF = 6'b000010,
        SST_WR = 6'b000100,
        SST_WR_WAIT = 6'b001000,
        SST_RD_WAIT = 6'b010000,
        SST_HOLD = 6'b100000
    } sst_state_t;

endpackage

// ### hdl/sst_axil_slave.sv
// axi4-lite slave front end producing register strobes
`timescale 1ns/100ps
`default_nettype none
`include "sst_consts.svh"
module sst_axil_slave
(
    input wire logic aclk, // bus clock
    input wire logic aresetn, // sync reset, low active
    input wire sst_pkg::sst_axil_req_t axi_req, // master signals
    output sst_pkg::sst_axil_rsp_t axi_rsp, // slave signals
    output logic wr_en, // register write pulse
    output logic [7:0] wr_addr, // write byte address
    output logic [7:0] wr_data, // write low byte
    output logic wr_byte0, // low byte lane enabled
    input wire logic wr_err, // write address unmapped
    output logic rd_en, // register read pulse
    output logic [7:0] rd_addr, // read byte address
    input wire logic [7:0] rd_data, // read value
    input wire logic rd_err // read address unmapped
);
    import sst_pkg::*;

    logic aw_have_ff;
    logic w_have_ff;
    logic [7:0] aw_addr_ff;
    logic [7:0] w_data_ff;
    logic w_b0_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [7:0] rdata_ff;
    logic [1:0] rresp_ff;
    wire aw_take = axi_req.awvalid && !aw_have_ff;
    wire w_take = axi_req.wvalid && !w_have_ff;
    wire ar_take = axi_req.arvalid && !rvalid_ff;

    assign wr_en = aw_have_ff && w_have_ff && !bvalid_ff;
    assign wr_addr = aw_addr_ff;
    assign wr_data = w_data_ff;
    assign wr_byte0 = w_b0_ff;
    assign rd_en = ar_take;
    assign rd_addr = axi_req.araddr;

    assign axi_rsp.awready = !aw_have_ff;
    assign axi_rsp.wready = !w_have_ff;
    assign axi_rsp.bvalid = bvalid_ff;
    assign axi_rsp.bresp = bresp_ff;
    assign axi_rsp.arready = !rvalid_ff;
    assign axi_rsp.rvalid = rvalid_ff;
    assign axi_rsp.rdata = {24'h000000, rdata_ff};
    assign axi_rsp.rresp = rresp_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff <= 8'h00;
            w_b0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `SST_RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                aw_have_ff <= 1'b1;
                aw_addr_ff <= axi_req.awaddr;
            end
            if (w_take)
            begin
                w_have_ff <= 1'b1;
                w_data_ff <= axi_req.wdata[7:0];
                w_b0_ff <= axi_req.wstrb[0];
            end
            if (wr_en)
            begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_err ? `SST_RESP_SLVERR : `SST_RESP_OKAY;
            end
            else if (bvalid_ff && axi_req.bready)
            begin
                bvalid_ff <= 1'b0;
                aw_have_ff <= 1'b0;
                w_have_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 8'h00;
            rresp_ff <= `SST_RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_err ? 8'h00 : rd_data;
            rresp_ff <= rd_err ? `SST_RESP_SLVERR : `SST_RESP_OKAY;
        end
        else if (rvalid_ff && axi_req.rready)
        begin
            rvalid_ff <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### hdl/sst_chan.sv
// one transfer channel: data register, access flag, bit mask decode
`timescale 1ns/100ps
`default_nettype none
`include "sst_consts.svh"
module sst_chan
(
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset, low active
    input wire logic cpu_we, // software writes data register
    input wire logic [7:0] cpu_wdata, // software write value
    input wire logic cpu_touch, // software read or write of data
    input wire logic clr_touch, // window closes
    input wire logic load_en, // receive location loaded
    input wire logic [7:0] load_data, // value read from memory
    input wire logic [2:0] chan_type, // channel type code
    input wire logic rx_cfi, // source is subscriber interface
    input wire logic tx_cfi, // destination is subscriber interface
    output logic [7:0] data, // data register
    output logic [7:0] rx_mask, // bits taken from receive slot
    output logic [7:0] tx_mask, // bits written to transmit slot
    output logic touched // accessed since window opened
);
    import sst_pkg::*;

    logic [7:0] data_ff;
    logic touched_ff;
    logic [7:0] type_mask;

    // bit 7 is first serial bit, so masks name register bits directly
    always_comb
    begin
        case (chan_type)
            3'h1: type_mask = 8'hff;
            3'h2: type_mask = 8'h0f;
            3'h3: type_mask = 8'hf0;
            3'h4: type_mask = 8'h03;
            3'h5: type_mask = 8'h0c;
            3'h6: type_mask = 8'h30;
            3'h7: type_mask = 8'hc0;
            default: type_mask = 8'h00;
        endcase
    end

    // subscriber side always moves the whole byte
    assign rx_mask = rx_cfi ? 8'hff : type_mask;
    assign tx_mask = tx_cfi ? 8'hff : type_mask;
    assign data = data_ff;
    assign touched = touched_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            data_ff <= `SST_REG_RESET;
            touched_ff <= 1'b0;
        end
        else
        begin
            if (load_en)
                data_ff <= (data_ff & ~rx_mask) |
                    (load_data & rx_mask);
            else if (cpu_we)
                data_ff <= cpu_wdata;
            if (cpu_touch)
                touched_ff <= 1'b1;
            else if (clr_touch)
                touched_ff <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### hdl/sst_top.sv
// two-channel frame synchronous transfer unit with axi4-lite registers
// Notes on behaviour
// - transfer writes overwrite any idle code stored at the target
// - pcm exchange may be limited to a 2-bit or 4-bit sub-slot
// - subscriber side uses control memory data field, not data memory
// - window-open event when access window opens; data registers usable then
// - overflow event if enabled channel untouched, before memory transfers
// - without new software value, last received value is transmitted
// - both events at fixed frame points, independent of slot positions
// - transfer cycle repeats once per 125 us frame
// - window closed at most 16 periods per enabled channel plus one
// - data bit 7 is first serial bit, bit 0 the last
// - receive address bit 7 picks interface, bits 6..0 port and slot
// - transmit address bit 7 picks interface, bits 6..0 port and slot
// - control bit 7 enables channel b, bit 6 channel a
// - control type fields: bits 5..3 for b, bits 2..0 for a
// - type codes: 000 illegal, 001 byte, 010/011 nibbles, 1xx bit pairs
// - window-open event only while at least one channel enabled
// - reading status clears window-open and overflow flags
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "sst_consts.svh"
module sst_top
(
    input wire logic aclk, // clock, 10 MHz
    input wire logic aresetn, // sync reset, low active
    input wire sst_pkg::sst_axil_req_t axi_req, // register bus in
    output sst_pkg::sst_axil_rsp_t axi_rsp, // register bus out
    input wire logic reference_clock, // frame reference clock pin
    output sst_pkg::sst_mem_req_t mem_req, // memory access request
    input wire logic mem_ack, // memory access done
    input wire logic [7:0] mem_rdata, // memory read value with ack
    output logic window_open, // access window open
    output logic window_open_event, // window opened, one cycle
    output logic window_overflow_event // data untouched, one cycle
);
    import sst_pkg::*;

    localparam logic [9:0] FRAME_RCL = 10'(`SST_FRAME_RCL);
    localparam logic [9:0] CLOSE_PER_CHAN = 10'(`SST_CLOSE_PER_CHAN);
    localparam logic [9:0] CLOSE_EXTRA = 10'(`SST_CLOSE_EXTRA);

    logic [7:0] rx_a_ff;
    logic [7:0] rx_b_ff;
    logic [7:0] tx_a_ff;
    logic [7:0] tx_b_ff;
    logic [7:0] ctrl_ff;
    logic [1:0] stat_ff;
    logic rcl_s1_ff;
    logic rcl_s2_ff;
    logic rcl_s3_ff;
    logic [9:0] rcl_cnt_ff;
    logic [9:0] close_end_ff;
    logic [1:0] en_ff;
    logic ch_ff;
    logic open_ff;
    logic open_evt_ff;
    logic ovf_evt_ff;
    sst_state_t state_ff;
    sst_mem_req_t mem_ff;

    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_byte0;
    logic rd_en;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic [7:0] data_a;
    logic [7:0] data_b;
    logic [7:0] rx_mask_a;
    logic [7:0] rx_mask_b;
    logic [7:0] tx_mask_a;
    logic [7:0] tx_mask_b;
    logic touched_a;
    logic touched_b;
    logic wr_unmapped;
    logic rd_unmapped;
    logic rd_data_sel_none;

    sst_axil_slave u_bus
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .axi_req(axi_req),
        .axi_rsp(axi_rsp),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_byte0(wr_byte0),
        .wr_err(wr_unmapped),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_unmapped)
    );

    // address decode
    wire w_data_a = wr_addr == `SST_OFS_DATA_A;
    wire w_data_b = wr_addr == `SST_OFS_DATA_B;
    wire w_rx_a = wr_addr == `SST_OFS_RX_A;
    wire w_rx_b = wr_addr == `SST_OFS_RX_B;
    wire w_tx_a = wr_addr == `SST_OFS_TX_A;
    wire w_tx_b = wr_addr == `SST_OFS_TX_B;
    wire w_ctrl = wr_addr == `SST_OFS_CTRL;
    wire w_stat = wr_addr == `SST_OFS_STATUS;
    assign wr_unmapped = !(w_data_a || w_data_b || w_rx_a || w_rx_b ||
        w_tx_a || w_tx_b || w_ctrl || w_stat);
    wire wr_go = wr_en && wr_byte0;
    wire r_data_a = rd_addr == `SST_OFS_DATA_A;
    wire r_data_b = rd_addr == `SST_OFS_DATA_B;
    wire r_stat = rd_addr == `SST_OFS_STATUS;
    assign rd_unmapped = rd_data_sel_none;

    always_comb
    begin
        rd_data_sel_none = 1'b0;
        if (r_data_a)
            rd_data = data_a;
        else if (r_data_b)
            rd_data = data_b;
        else if (rd_addr == `SST_OFS_RX_A)
            rd_data = rx_a_ff;
        else if (rd_addr == `SST_OFS_RX_B)
            rd_data = rx_b_ff;
        else if (rd_addr == `SST_OFS_TX_A)
            rd_data = tx_a_ff;
        else if (rd_addr == `SST_OFS_TX_B)
            rd_data = tx_b_ff;
        else if (rd_addr == `SST_OFS_CTRL)
            rd_data = ctrl_ff;
        else if (r_stat)
            rd_data = {6'h00, stat_ff};
        else
        begin
            rd_data = 8'h00;
            rd_data_sel_none = 1'b1;
        end
    end

    // data register traffic counts only while the window is open
    wire touch_a = open_ff && ((rd_en && r_data_a) || (wr_go && w_data_a));
    wire touch_b = open_ff && ((rd_en && r_data_b) || (wr_go && w_data_b));
    wire [1:0] en_now = {ctrl_ff[`SST_CTRL_EN_B],
        ctrl_ff[`SST_CTRL_EN_A]};
    wire [2:0] type_a =
        ctrl_ff[`SST_CTRL_TYPE_A_HI:`SST_CTRL_TYPE_A_LO];
    wire [2:0] type_b =
        ctrl_ff[`SST_CTRL_TYPE_B_HI:`SST_CTRL_TYPE_B_LO];
    wire load_hit = state_ff == SST_RD_WAIT && mem_ack;

    sst_chan u_chan_a
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .cpu_we(wr_go && w_data_a && open_ff),
        .cpu_wdata(wr_data),
        .cpu_touch(touch_a),
        .clr_touch(state_ff == SST_OVF),
        .load_en(load_hit && !ch_ff),
        .load_data(mem_rdata),
        .chan_type(type_a),
        .rx_cfi(rx_a_ff[`SST_ADDR_IFACE]),
        .tx_cfi(tx_a_ff[`SST_ADDR_IFACE]),
        .data(data_a),
        .rx_mask(rx_mask_a),
        .tx_mask(tx_mask_a),
        .touched(touched_a)
    );

    sst_chan u_chan_b
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .cpu_we(wr_go && w_data_b && open_ff),
        .cpu_wdata(wr_data),
        .cpu_touch(touch_b),
        .clr_touch(state_ff == SST_OVF),
        .load_en(load_hit && ch_ff),
        .load_data(mem_rdata),
        .chan_type(type_b),
        .rx_cfi(rx_b_ff[`SST_ADDR_IFACE]),
        .tx_cfi(tx_b_ff[`SST_ADDR_IFACE]),
        .data(data_b),
        .rx_mask(rx_mask_b),
        .tx_mask(tx_mask_b),
        .touched(touched_b)
    );

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_a_ff <= `SST_REG_RESET;
            rx_b_ff <= `SST_REG_RESET;
            tx_a_ff <= `SST_REG_RESET;
            tx_b_ff <= `SST_REG_RESET;
            ctrl_ff <= `SST_REG_RESET;
        end
        else if (wr_go)
        begin
            if (w_rx_a)
                rx_a_ff <= wr_data;
            else if (w_rx_b)
                rx_b_ff <= wr_data;
            else if (w_tx_a)
                tx_a_ff <= wr_data;
            else if (w_tx_b)
                tx_b_ff <= wr_data;
            else if (w_ctrl)
                ctrl_ff <= wr_data;
        end
    end

    // reference clock pin resynchronised before edge detection
    wire rcl_rise = rcl_s2_ff && !rcl_s3_ff;
    wire frame_start = rcl_rise && rcl_cnt_ff == FRAME_RCL - 10'd1;
    wire [9:0] nxt_close_end = CLOSE_PER_CHAN * 10'(en_now[0]) +
        CLOSE_PER_CHAN * 10'(en_now[1]) + CLOSE_EXTRA;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rcl_s1_ff <= 1'b0;
            rcl_s2_ff <= 1'b0;
            rcl_s3_ff <= 1'b0;
            rcl_cnt_ff <= 10'd0;
        end
        else
        begin
            rcl_s1_ff <= reference_clock;
            rcl_s2_ff <= rcl_s1_ff;
            rcl_s3_ff <= rcl_s2_ff;
            if (frame_start)
                rcl_cnt_ff <= 10'd0;
            else if (rcl_rise)
                rcl_cnt_ff <= rcl_cnt_ff + 10'd1;
        end
    end

    // transfer sequencer: overflow check, store then load per channel
    wire [1:0] untouched = en_ff & ~{touched_b, touched_a};
    // closed span counts the frame start rise, so open one rise earlier
    wire open_point = rcl_rise && rcl_cnt_ff == close_end_ff - 10'd1;
    wire next_ch_ok = !ch_ff && en_ff[1];
    wire [7:0] tx_addr = ch_ff ? tx_b_ff : tx_a_ff;
    wire [7:0] rx_addr = ch_ff ? rx_b_ff : rx_a_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_ff <= SST_OPEN;
            ch_ff <= 1'b0;
            en_ff <= 2'b00;
            close_end_ff <= 10'd0;
            open_ff <= 1'b0;
            open_evt_ff <= 1'b0;
            ovf_evt_ff <= 1'b0;
            mem_ff <= '0;
        end
        else
        begin
            open_evt_ff <= 1'b0;
            ovf_evt_ff <= 1'b0;
            case (state_ff)
                SST_OPEN:
                    if (frame_start && en_now != 2'b00)
                    begin
                        en_ff <= en_now;
                        close_end_ff <= nxt_close_end;
                        open_ff <= 1'b0;
                        state_ff <= SST_OVF;
                    end
                    else if (frame_start)
                        open_ff <= 1'b0;
                SST_OVF:
                begin
                    ovf_evt_ff <= untouched != 2'b00;
                    ch_ff <= !en_ff[0];
                    state_ff <= SST_WR;
                end
                SST_WR:
                begin
                    // data register goes out first, so unchanged data repeats
                    mem_ff.req <= 1'b1;
                    mem_ff.we <= 1'b1;
                    mem_ff.cm_sel <= tx_addr[`SST_ADDR_IFACE];
                    mem_ff.addr <= tx_addr[6:0];
                    mem_ff.wdata <= ch_ff ? data_b : data_a;
                    mem_ff.wmask <= ch_ff ? tx_mask_b : tx_mask_a;
                    state_ff <= SST_WR_WAIT;
                end
                SST_WR_WAIT:
                    if (mem_ack)
                    begin
                        mem_ff.we <= 1'b0;
                        mem_ff.cm_sel <= rx_addr[`SST_ADDR_IFACE];
                        mem_ff.addr <= rx_addr[6:0];
                        mem_ff.wmask <= 8'h00;
                        state_ff <= SST_RD_WAIT;
                    end
                SST_RD_WAIT:
                    if (mem_ack)
                    begin
                        mem_ff.req <= 1'b0;
                        if (next_ch_ok)
                        begin
                            ch_ff <= 1'b1;
                            state_ff <= SST_WR;
                        end
                        else
                            state_ff <= SST_HOLD;
                    end
                SST_HOLD:
                    if (open_point)
                    begin
                        open_ff <= 1'b1;
                        open_evt_ff <= 1'b1;
                        state_ff <= SST_OPEN;
                    end
                default:
                    state_ff <= SST_OPEN;
            endcase
        end
    end

    // status flags: a new event beats the clear of a read
    wire [1:0] stat_set = {open_evt_ff, ovf_evt_ff};
    wire [1:0] stat_clr = (rd_en && r_stat) ? 2'b11 : 2'b00;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            stat_ff <= 2'b00;
        else
            stat_ff <= (stat_ff & ~stat_clr) | stat_set;
    end

    assign mem_req = mem_ff;
    assign window_open = open_ff;
    assign window_open_event = open_evt_ff;
    assign window_overflow_event = ovf_evt_ff;
endmodule
`default_nettype wire

// ### test/sst_top_monitor.sv
// port checks for the transfer unit
`timescale 1ns/100ps
`default_nettype none
module sst_top_monitor
(
    input wire logic aclk, // clk
    input wire logic aresetn, // reset
    input wire sst_pkg::sst_axil_req_t axi_req, // bus in
    input wire sst_pkg::sst_axil_rsp_t axi_rsp, // bus out
    input wire logic reference_clock, // rcl
    input wire sst_pkg::sst_mem_req_t mem_req, // mem req
    input wire logic mem_ack, // mem ack
    input wire logic [7:0] mem_rdata, // mem data
    input wire logic window_open, // window
    input wire logic window_open_event, // open pulse
    input wire logic window_overflow_event // ovf pulse
);
    import sst_pkg::*;
    logic rcl_q_ff;
    logic seen_ff;
    logic [7:0] shut_ff;
    wire rcl_rise = reference_clock & ~rcl_q_ff;
    always_ff @(posedge aclk)
    begin
        rcl_q_ff <= reference_clock;
        if (!aresetn)
        begin
            seen_ff <= 1'b0;
            shut_ff <= 8'h00;
        end
        else
        begin
            seen_ff <= seen_ff | window_open_event;
            if (window_open)
                shut_ff <= 8'h00;
            else if (rcl_rise)
                shut_ff <= shut_ff + 8'h01;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    open_pulse_a: assert property (
        window_open_event |-> window_open && !$past(window_open))
        else $error("open event without window rising");
    ovf_closed_a: assert property (
        window_overflow_event |-> !window_open && !mem_req.req)
        else $error("overflow not ahead of transfers");
    ovf_first_a: assert property (
        window_overflow_event |-> ##[1:4] mem_req.req && mem_req.we)
        else $error("no transfer after overflow");
    idle_open_a: assert property (
        window_open |-> !mem_req.req)
        else $error("memory access while window open");
    req_hold_a: assert property (
        mem_req.req && !mem_ack |=> $stable(mem_req))
        else $error("request changed before ack");
    wr_rd_a: assert property (
        mem_req.req && mem_req.we && mem_ack |=>
        mem_req.req && !mem_req.we && mem_req.wmask == 8'h00)
        else $error("store not followed by load");
    cfi_full_a: assert property (
        mem_req.req && mem_req.we && mem_req.cm_sel |->
        mem_req.wmask == 8'hff)
        else $error("subscriber store not full byte");
    shut_len_a: assert property (
        window_open_event && seen_ff |-> shut_ff <= 8'h21)
        else $error("window closed too long");
endmodule
bind sst_top sst_top_monitor mon (.aclk(aclk), .aresetn(aresetn),
    .axi_req(axi_req), .axi_rsp(axi_rsp), .reference_clock(reference_clock),
    .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .window_open(window_open), .window_open_event(window_open_event),
    .window_overflow_event(window_overflow_event));
`default_nettype wire

// ### test/sst_mem_model.sv
// data memory and control memory data field partner
`timescale 1ns/100ps
`default_nettype none
module sst_mem_model
(
    input wire logic aclk, // clk
    input wire sst_pkg::sst_mem_req_t mem_req, // request
    input wire logic slow, // late answers
    output logic mem_ack, // done pulse
    output logic [7:0] mem_rdata // read value
);
    import sst_pkg::*;
    logic [7:0] mem [256];
    logic [1:0] wait_ff;
    wire [7:0] idx = {mem_req.cm_sel, mem_req.addr};
    wire [7:0] wm = mem_req.wmask;
    wire go = mem_req.req && !mem_ack && wait_ff == (slow ? 2'd3 : 2'd0);
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = i[7:0] ^ 8'h3c;
        mem_ack = 1'b0;
        mem_rdata = 8'h00;
        wait_ff = 2'd0;
    end
    always @(posedge aclk)
    begin
        mem_ack <= go;
        wait_ff <= (mem_req.req && !mem_ack && !go) ? wait_ff + 2'd1 : 2'd0;
        // idle data bus never holds its last value
        mem_rdata <= ~mem_rdata;
        if (go && mem_req.we)
            mem[idx] <= (mem[idx] & ~wm) | (mem_req.wdata & wm);
        if (go && !mem_req.we)
            mem_rdata <= mem[idx];
    end
endmodule
`default_nettype wire

// ### test/sync_timeslot_transfer_test.sv
// self-checking bench for the transfer unit
`timescale 1ns/100ps
`default_nettype none
module sync_timeslot_transfer_test;
    import sst_pkg::*;
    logic aclk, aresetn, ack, wo, woe, wovf, slow, ovf;
    sst_axil_req_t rq;
    sst_axil_rsp_t rs;
    sst_mem_req_t mq;
    logic [7:0] rdat;
    logic [1:0] rdiv;
    logic [31:0] got;
    int err_total, tests_run, gap, shut;
    sst_top uut (.aclk(aclk), .aresetn(aresetn), .axi_req(rq), .axi_rsp(rs),
        .reference_clock(rdiv[1]), .mem_req(mq), .mem_ack(ack),
        .mem_rdata(rdat), .window_open(wo), .window_open_event(woe),
        .window_overflow_event(wovf));
    sst_mem_model pm (.aclk(aclk), .mem_req(mq), .slow(slow),
        .mem_ack(ack), .mem_rdata(rdat));
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk)
        rdiv <= rdiv + 2'd1;
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        @(posedge aclk);
        rq.awaddr <= a;
        rq.wdata <= {24'h0, d};
        rq.awvalid <= 1'b1;
        rq.wvalid <= 1'b1;
        rq.bready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (rs.awready) rq.awvalid <= 1'b0;
            if (rs.wready) rq.wvalid <= 1'b0;
            if (rs.bvalid) break;
        end
        rq.bready <= 1'b0;
        chk({30'h0, rs.bresp}, {30'h0, r});
    endtask
    task rd(input logic [7:0] a, input logic [1:0] r);
        @(posedge aclk);
        rq.araddr <= a;
        rq.arvalid <= 1'b1;
        rq.rready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (rs.arready) rq.arvalid <= 1'b0;
            if (rs.rvalid) break;
        end
        rq.rready <= 1'b0;
        got = rs.rdata;
        chk({30'h0, rs.rresp}, {30'h0, r});
    endtask
    task wait_evt(input int lim);
        gap = 0;
        shut = 0;
        ovf = 1'b0;
        while (gap < lim)
        begin
            @(posedge aclk);
            gap++;
            shut += !wo;
            ovf |= wovf;
            if (woe) break;
        end
    endtask
    task t_regs;
        logic [7:0] a [5] = '{8'h08, 8'h10, 8'h0c, 8'h14, 8'h18};
        logic [7:0] v [5] = '{8'h05, 8'h09, 8'h92, 8'h94, 8'h41};
        for (int i = 0; i < 32; i += 4)
        begin
            rd(i[7:0], 2'b00);
            chk(got, 0);
        end
        rd(8'h20, 2'b10);
        wr(8'h20, 8'h55, 2'b10);
        // tx slot 9 has no other writer
        for (int i = 0; i < 5; i++)
        begin
            wr(a[i], v[i], 2'b00);
            rd(a[i], 2'b00);
            chk(got, {24'h0, v[i]});
        end
    endtask
    task t_loop;
        wait_evt(3000);
        chk(gap < 3000, 1);
        chk(ovf, 1);
        rd(8'h1c, 2'b00);
        chk(got, 3);
        rd(8'h1c, 2'b00);
        chk(got, 0);
        rd(8'h00, 2'b00);
        chk(got, 8'h39);
        chk(pm.mem[8'h09], 0);
        wr(8'h00, 8'hc3, 2'b00);
        wait_evt(3000);
        chk(ovf, 0);
        chk(pm.mem[8'h09], 8'hc3);
        chk(shut <= 68, 1);
        rd(8'h00, 2'b00);
        wait_evt(3000);
        chk(pm.mem[8'h09], 8'h39);
        wait_evt(3000);
        chk(ovf, 1);
        chk(gap, 2048);
    endtask
    task t_both;
        slow <= 1'b1;
        wr(8'h00, 8'hff, 2'b00);
        // subscriber channel b full byte, a top bit pair
        wr(8'h18, 8'hcf, 2'b00);
        wait_evt(3000);
        chk(ovf, 1);
        chk(shut <= 132, 1);
        chk(pm.mem[8'h09], 8'hf9);
        chk(pm.mem[8'h94], 0);
        rd(8'h00, 2'b00);
        chk(got, 8'h3f);
        rd(8'h04, 2'b00);
        chk(got, 8'hae);
        wr(8'h18, 8'h0f, 2'b00);
        wait_evt(3000);
        chk(gap, 3000);
        chk(wo, 0);
        wr(8'h00, 8'h12, 2'b00);
        rd(8'h00, 2'b00);
        chk(got, 8'h3f);
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (30000) @(posedge aclk);
        err_total++;
        report_and_stop;
    end
    initial
    begin
        err_total = 0;
        tests_run = 0;
        rq = '0;
        rq.wstrb = 4'hf;
        aresetn = 1'b0;
        slow = 1'b0;
        rdiv = 2'd0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_loop;
        t_both;
        report_and_stop;
    end
endmodule
`default_nettype wire
